// ===== logic/ahs_top.sv
// accumulator shift and halfword-pair shift datapath
// Overview of operation
// RULE1: accumulator shifts join upper and lower words, shift, write back.
// RULE2: accumulator shift amount is six-bit signed; top bit picks direction.
// RULE3: positive amount shifts right up to 31, zeros fill the top.
// RULE4: negative amount shifts left up to 32, zeros fill the bottom.
// RULE5: shift is logical; zero amount leaves the accumulator unchanged.
// RULE6: two-bit select picks one of four accumulators; 0 is the base pair.
// RULE7: variable form uses source register low six bits only.
// RULE8: each halfword shifts left independently by one amount, zero filled.
// RULE9: halfword amount is a four-bit field; zero passes values unchanged.
// RULE10: shifted halfwords land in matching destination halves.
// RULE11: overflow when sign and lost bits are not all equal.
// RULE12: saturating form clamps to 0x7fff or 0x8000 by original sign.
// RULE13: any halfword overflow sets control bit 22, else bit unchanged.
// RULE14: no exception ever depends on operand data.
// RULE15: absent or disabled extension raises an exception instead.
// RULE16: operands arrive in one cycle; results answer one cycle later.
`timescale 1ns/1ps
`include "ahs_consts.svh"
module ahs_top import ahs_pkg::*; (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// request from decode
	input wire logic op_valid_i,
	input ahs_op_t op_kind_i,
	input wire logic [`AHS_SEL_W-1:0] accum_select_i,
	input wire logic [`AHS_ACC_AMT_W-1:0] shift_amount_field_i,
	input wire logic [`AHS_WORD_W-1:0] source_gpr_i,
	input wire logic [`AHS_WORD_W-1:0] acc_upper_word_i,
	input wire logic [`AHS_WORD_W-1:0] acc_lower_word_i,
	input wire logic [`AHS_WORD_W-1:0] dsp_control_reg_i,
	// extension state
	input wire logic dsp_present_i,
	input wire logic dsp_enable_i,
	// accumulator write back
	output logic acc_wr_o,
	output logic [`AHS_SEL_W-1:0] accum_select_o,
	output logic [`AHS_WORD_W-1:0] acc_upper_word_o,
	output logic [`AHS_WORD_W-1:0] acc_lower_word_o,
	// target register write back
	output logic gpr_wr_o,
	output logic [`AHS_WORD_W-1:0] target_gpr_o,
	// control register update
	output logic dsp_ctl_wr_o,
	output logic [`AHS_WORD_W-1:0] dsp_control_reg_o,
	// exceptions
	output logic exc_resv_o,
	output logic exc_dsp_off_o
);
	// ********************************************************
	// decode
	// ********************************************************
	logic go_w;
	logic acc_op_w;
	logic half_op_w;
	logic sat_w;
	assign go_w = op_valid_i && dsp_present_i && dsp_enable_i;
	assign acc_op_w = (op_kind_i == ahs_accum_shift_imm) ||
		(op_kind_i == ahs_accum_shift_var);
	assign half_op_w = !acc_op_w;
	assign sat_w = (op_kind_i == ahs_pair_half_shift_left_sat);

	// ********************************************************
	// accumulator shift
	// ********************************************************
	logic [`AHS_ACC_AMT_W-1:0] acc_amt_w;
	logic [`AHS_ACC_AMT_W-1:0] acc_mag_w;
	logic acc_left_w;
	logic [`AHS_ACC_W-1:0] acc_in_w;
	logic [`AHS_ACC_W-1:0] acc_res_w;
	// RULE7: low six source bits
	assign acc_amt_w = (op_kind_i == ahs_accum_shift_var) ?
		source_gpr_i[`AHS_ACC_AMT_W-1:0] : shift_amount_field_i;
	// RULE2: sign picks direction
	assign acc_left_w = acc_amt_w[`AHS_ACC_AMT_W-1];
	assign acc_mag_w = acc_left_w ? -acc_amt_w : acc_amt_w;
	// RULE1: one 64-bit value
	assign acc_in_w = {acc_upper_word_i, acc_lower_word_i};
	// RULE3: logical right, RULE4: logical left, RULE5: zero passes
	assign acc_res_w = acc_left_w ? (acc_in_w << acc_mag_w) :
		(acc_in_w >> acc_mag_w);

	// ********************************************************
	// halfword pair shift
	// ********************************************************
	logic [1:0][`AHS_HALF_W-1:0] half_res_w;
	logic [1:0] half_ovf_w;
	logic ovf_any_w;
	genvar ln;
	generate
		for (ln = 0; ln < 2; ln++) begin : g_lane
			// RULE9: four-bit amount field
			ahs_half_shift u_lane (
				.half_i(source_gpr_i[ln*`AHS_HALF_W +: `AHS_HALF_W]),
				.amt_i(shift_amount_field_i[`AHS_HALF_AMT_W-1:0]),
				.sat_i(sat_w),
				.half_o(half_res_w[ln]),
				.ovf_o(half_ovf_w[ln])
			);
		end
	endgenerate
	assign ovf_any_w = |half_ovf_w;

	// ********************************************************
	// next values
	// ********************************************************
	logic acc_wr_nxt;
	logic gpr_wr_nxt;
	logic ctl_wr_nxt;
	logic resv_nxt;
	logic off_nxt;
	logic [`AHS_WORD_W-1:0] ctl_nxt;
	assign acc_wr_nxt = go_w && acc_op_w;
	assign gpr_wr_nxt = go_w && half_op_w;
	// RULE13: set bit 22 only on overflow
	assign ctl_wr_nxt = gpr_wr_nxt && ovf_any_w;
	assign ctl_nxt = dsp_control_reg_i |
		(`AHS_WORD_W'(1) << `AHS_OUFLAG_BIT);
	// RULE15: absent beats disabled; RULE14: data never involved
	assign resv_nxt = op_valid_i && !dsp_present_i;
	assign off_nxt = op_valid_i && dsp_present_i && !dsp_enable_i;

	// ********************************************************
	// output registers
	// ********************************************************
	// RULE16: answer one edge after request
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			acc_wr_o <= 1'b0;
			gpr_wr_o <= 1'b0;
			dsp_ctl_wr_o <= 1'b0;
			exc_resv_o <= 1'b0;
			exc_dsp_off_o <= 1'b0;
		end else begin
			acc_wr_o <= acc_wr_nxt;
			gpr_wr_o <= gpr_wr_nxt;
			dsp_ctl_wr_o <= ctl_wr_nxt;
			exc_resv_o <= resv_nxt;
			exc_dsp_off_o <= off_nxt;
		end
	end

	// data held between operations to save toggling
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			accum_select_o <= '0;
			acc_upper_word_o <= '0;
			acc_lower_word_o <= '0;
		end else if (acc_wr_nxt) begin
			// RULE6: same accumulator back
			accum_select_o <= accum_select_i;
			acc_upper_word_o <= acc_res_w[`AHS_ACC_W-1:`AHS_WORD_W];
			acc_lower_word_o <= acc_res_w[`AHS_WORD_W-1:0];
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			target_gpr_o <= '0;
			dsp_control_reg_o <= '0;
		end else if (gpr_wr_nxt) begin
			// RULE10: lanes keep their halves
			target_gpr_o <= {half_res_w[1], half_res_w[0]};
			dsp_control_reg_o <= ctl_nxt;
		end
	end

	// ********************************************************
	// checks
	// ********************************************************
	logic [`AHS_HALF_W-1:0] src_lo_w;
	logic [`AHS_HALF_AMT_W-1:0] half_amt_w;
	assign src_lo_w = source_gpr_i[`AHS_HALF_W-1:0];
	assign half_amt_w = shift_amount_field_i[`AHS_HALF_AMT_W-1:0];

	a_acc_select: assert property (@(posedge ref_clk_i) // RULE6
		disable iff (!arst_n_i)
		acc_wr_nxt |=> acc_wr_o && !gpr_wr_o &&
		accum_select_o == $past(accum_select_i))
		else $error("accumulator write back missing");
	a_acc_right: assert property (@(posedge ref_clk_i) // RULE3
		disable iff (!arst_n_i)
		acc_wr_nxt && !acc_left_w |=>
		{acc_upper_word_o, acc_lower_word_o} ==
		($past(acc_in_w) >> $past(acc_amt_w)))
		else $error("right shift wrong");
	a_acc_left: assert property (@(posedge ref_clk_i) // RULE4
		disable iff (!arst_n_i)
		acc_wr_nxt && acc_left_w |=>
		{acc_upper_word_o, acc_lower_word_o} ==
		($past(acc_in_w) << $past(acc_mag_w)) &&
		$past(acc_mag_w) != '0)
		else $error("left shift wrong");
	a_acc_zero: assert property (@(posedge ref_clk_i) // RULE5
		disable iff (!arst_n_i)
		acc_wr_nxt && acc_amt_w == '0 |=>
		acc_upper_word_o == $past(acc_upper_word_i) &&
		acc_lower_word_o == $past(acc_lower_word_i))
		else $error("zero shift changed value");
	a_var_amount: assert property (@(posedge ref_clk_i) // RULE7
		disable iff (!arst_n_i)
		go_w && op_kind_i == ahs_accum_shift_var |->
		acc_amt_w == source_gpr_i[`AHS_ACC_AMT_W-1:0])
		else $error("variable amount wrong");
	a_half_lane: assert property (@(posedge ref_clk_i) // RULE8
		disable iff (!arst_n_i)
		gpr_wr_nxt && !sat_w |=>
		target_gpr_o[`AHS_HALF_W-1:0] ==
		`AHS_HALF_W'($past(src_lo_w) << $past(half_amt_w)))
		else $error("halfword shift wrong");
	a_half_sat: assert property (@(posedge ref_clk_i) // RULE12
		disable iff (!arst_n_i)
		gpr_wr_nxt && sat_w && half_ovf_w[0] |=>
		target_gpr_o[`AHS_HALF_W-1:0] ==
		($past(src_lo_w[`AHS_HALF_W-1]) ? `AHS_SAT_NEG : `AHS_SAT_POS))
		else $error("saturation value wrong");
	a_ouflag_set: assert property (@(posedge ref_clk_i) // RULE13
		disable iff (!arst_n_i)
		gpr_wr_nxt |=> dsp_ctl_wr_o == $past(ovf_any_w) &&
		dsp_control_reg_o[`AHS_OUFLAG_BIT])
		else $error("overflow flag wrong");
	a_exc_block: assert property (@(posedge ref_clk_i) // RULE15
		disable iff (!arst_n_i)
		op_valid_i && !(dsp_present_i && dsp_enable_i) |=>
		(exc_resv_o ^ exc_dsp_off_o) && !acc_wr_o && !gpr_wr_o &&
		!dsp_ctl_wr_o)
		else $error("disabled op executed");
	a_no_data_exc: assert property (@(posedge ref_clk_i) // RULE14
		disable iff (!arst_n_i)
		go_w |=> !exc_resv_o && !exc_dsp_off_o && (acc_wr_o || gpr_wr_o))
		else $error("data exception or lost op");
	// left by the full magnitude is the only case with the top bit set
	c_acc_left: cover property (@(posedge ref_clk_i)
		disable iff (!arst_n_i)
		acc_wr_nxt && acc_left_w && acc_mag_w[`AHS_ACC_AMT_W-1]);
	c_half_sat: cover property (@(posedge ref_clk_i)
		disable iff (!arst_n_i)
		gpr_wr_nxt && sat_w && ovf_any_w);
	c_disabled: cover property (@(posedge ref_clk_i)
		disable iff (!arst_n_i)
		off_nxt);
endmodule

// ===== logic/ahs_consts.svh
// constants for the accumulator and halfword shifter
`ifndef AHS_CONSTS_SVH
`define AHS_CONSTS_SVH
`define AHS_ACC_AMT_W 6
`define AHS_HALF_AMT_W 4
`define AHS_HALF_W 16
`define AHS_WORD_W 32
`define AHS_ACC_W 64
`define AHS_SEL_W 2
`define AHS_OUFLAG_BIT 22
`define AHS_SAT_POS 16'h7fff
`define AHS_SAT_NEG 16'h8000
`define AHS_DISC_ZERO 16'h0000
`define AHS_DISC_ONES 16'hffff
`define AHS_HALF_TOP 4'hf
`endif

// ===== logic/ahs_pkg.sv
// types for the accumulator and halfword shifter
package ahs_pkg;
	typedef enum logic [1:0] {
		ahs_accum_shift_imm,
		ahs_accum_shift_var,
		ahs_pair_half_shift_left,
		ahs_pair_half_shift_left_sat
	} ahs_op_t;
endpackage

// ===== logic/ahs_half_shift.sv
// one halfword lane: left shift, overflow detect, optional saturation
`timescale 1ns/1ps
`include "ahs_consts.svh"
module ahs_half_shift (
	// operand
	input wire logic [`AHS_HALF_W-1:0] half_i,
	input wire logic [`AHS_HALF_AMT_W-1:0] amt_i,
	input wire logic sat_i,
	// result
	output logic [`AHS_HALF_W-1:0] half_o,
	output logic ovf_o
);
	logic [`AHS_HALF_W-1:0] shifted_w;
	logic [`AHS_HALF_W-1:0] discard_w;
	// RULE8: zeros fill low bits
	assign shifted_w = half_i << amt_i;
	// RULE11: sign plus lost bits must agree
	assign discard_w = $signed(half_i) >>> (`AHS_HALF_TOP - amt_i);
	assign ovf_o = (discard_w != `AHS_DISC_ZERO) &&
		(discard_w != `AHS_DISC_ONES);
	// RULE12: clamp by original sign
	assign half_o = (sat_i && ovf_o) ?
		(half_i[`AHS_HALF_W-1] ? `AHS_SAT_NEG : `AHS_SAT_POS) : shifted_w;
endmodule

// ===== testbench/ahs_core_model.sv
// core register file model holding the four accumulators
`timescale 1ns/1ps
`include "ahs_consts.svh"
module ahs_core_model (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// read side toward the shifter
	input wire logic [`AHS_SEL_W-1:0] rd_sel_i,
	output logic [`AHS_WORD_W-1:0] up_o,
	output logic [`AHS_WORD_W-1:0] lo_o,
	// write back from the shifter
	input wire logic wr_i,
	input wire logic [`AHS_SEL_W-1:0] wr_sel_i,
	input wire logic [`AHS_WORD_W-1:0] up_i,
	input wire logic [`AHS_WORD_W-1:0] lo_i
);
	// ****************************************
	// accumulator file
	// ****************************************
	logic [`AHS_ACC_W-1:0] acc_r [4];
	assign {up_o, lo_o} = acc_r[rd_sel_i];
	// four pairs, whole write
	// distinct reset patterns so a wrong select shows at once
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < 4; i++) begin
				acc_r[i] <= {30'h2aaa_aaaa, i[1:0], 30'h1555_5555, i[1:0]};
			end
		end else if (wr_i) begin
			acc_r[wr_sel_i] <= {up_i, lo_i};
		end
	end
endmodule

// ===== testbench/accum_and_halfword_shifter_bench.sv
// self-checking bench for the accumulator and halfword shifter
`timescale 1ns/1ps
`include "ahs_consts.svh"
module accum_and_halfword_shifter_bench import ahs_pkg::*;;
	typedef struct {
		logic aw; logic [1:0] s; logic [63:0] a; logic gw; logic [31:0] g;
		logic cw; logic [31:0] c; logic er; logic ed; int t;
	} ahs_note_t;
	ahs_note_t q[$];
	logic ref_clk_i = 0, arst_n_i = 0, op_valid_i = 0, pres = 1, en = 1;
	ahs_op_t op_kind_i = ahs_accum_shift_imm;
	logic [1:0] sel = 0, s_o;
	logic [5:0] amt = 0;
	logic [31:0] src = 0, ctl = 0, up, lo, up_o, lo_o, g_o, c_o;
	logic aw_o, gw_o, cw_o, er_o, ed_o;
	logic [31:0] rnd = 32'h3f50;
	logic [5:0] am_t[6] = '{6'h00, 6'h01, 6'h1f, 6'h3f, 6'h20, 6'h21};
	logic [31:0] hw_t[4] = '{32'h4000_0001, 32'h8000_7fff, 32'hffff_0001,
		32'hc000_3fff};
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	always #50 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) cyc <= cyc + 1;
	ahs_top uut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
		.op_valid_i(op_valid_i), .op_kind_i(op_kind_i),
		.accum_select_i(sel), .shift_amount_field_i(amt),
		.source_gpr_i(src), .acc_upper_word_i(up), .acc_lower_word_i(lo),
		.dsp_control_reg_i(ctl), .dsp_present_i(pres), .dsp_enable_i(en),
		.acc_wr_o(aw_o), .accum_select_o(s_o), .acc_upper_word_o(up_o),
		.acc_lower_word_o(lo_o), .gpr_wr_o(gw_o), .target_gpr_o(g_o),
		.dsp_ctl_wr_o(cw_o), .dsp_control_reg_o(c_o), .exc_resv_o(er_o),
		.exc_dsp_off_o(ed_o));
	ahs_core_model core (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
		.rd_sel_i(sel), .up_o(up), .lo_o(lo), .wr_i(aw_o), .wr_sel_i(s_o),
		.up_i(up_o), .lo_i(lo_o));
	// ****************************************
	// helpers
	// ****************************************
	function logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0);
	endfunction
	// lost bits must match the sign
	function logic [15:0] hs(logic [15:0] a, logic [3:0] s, logic st,
		output logic ov);
		logic [15:0] t;
		t = a << s;
		ov = ($signed(t) >>> s) != $signed(a);
		return (ov && st) ? (a[15] ? 16'h8000 : 16'h7fff) : t;
	endfunction
	task chk(logic ok, string m);
		checks_done++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task complete_run();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task issue(ahs_op_t k, logic [1:0] sl, logic [5:0] am, logic [31:0] sr,
		logic p, logic e);
		ahs_note_t n;
		logic [5:0] a6;
		logic [63:0] v;
		logic o1, o0, st;
		@(negedge ref_clk_i);
		rnd = lfsr(rnd);
		op_valid_i = 1;
		op_kind_i = k;
		sel = sl;
		amt = am;
		src = sr;
		pres = p;
		en = e;
		ctl = rnd;
		#1;
		n = '{default: 0};
		n.t = cyc + 1;
		n.er = !p;
		n.ed = p && !e;
		a6 = (k == ahs_accum_shift_var) ? sr[5:0] : am;
		v = {up, lo};
		st = (k == ahs_pair_half_shift_left_sat);
		if (p && e && (k == ahs_accum_shift_imm ||
			k == ahs_accum_shift_var)) begin
			n.aw = 1;
			n.s = sl;
			n.a = a6[5] ? v << (6'd0 - a6) : v >> a6;
		end else if (p && e) begin
			n.gw = 1;
			n.g = {hs(sr[31:16], am[3:0], st, o1),
				hs(sr[15:0], am[3:0], st, o0)};
			n.cw = o1 | o0;
			n.c = ctl | (32'h1 << `AHS_OUFLAG_BIT);
		end
		q.push_back(n);
	endtask
	// ****************************************
	// result monitor
	// ****************************************
	always @(negedge ref_clk_i) begin : mon
		ahs_note_t n;
		if ((aw_o | gw_o | cw_o | er_o | ed_o) === 1'b1) begin
			if (q.size() == 0) chk(0, "result with no request");
			else begin
				n = q.pop_front();
				chk(n.t == cyc, "late or early result");
				chk({aw_o, gw_o, cw_o, er_o, ed_o} ===
					{n.aw, n.gw, n.cw, n.er, n.ed}, "strobes");
				chk(!n.aw || {s_o, up_o, lo_o} === {n.s, n.a}, "accum");
				chk(!n.gw || g_o === n.g, "halfwords");
				chk(!n.cw || c_o === n.c, "control word");
			end
		end
	end
	initial begin
		#(100 * 3000);
		n_mismatch++;
		complete_run();
	end
	initial begin
		repeat (5) @(posedge ref_clk_i);
		@(negedge ref_clk_i) arst_n_i = 1;
		foreach (am_t[i]) for (int s = 0; s < 4; s++) begin
			issue(ahs_accum_shift_imm, s[1:0], am_t[i], rnd, 1, 1);
			issue(ahs_accum_shift_var, s[1:0], rnd[5:0], {rnd[31:6], am_t[i]},
				1, 1);
		end
		foreach (am_t[i]) foreach (hw_t[j]) begin
			issue(ahs_pair_half_shift_left, 0, {rnd[5:4], am_t[i][3:0]},
				hw_t[j], 1, 1);
			issue(ahs_pair_half_shift_left_sat, 0, {rnd[5:4], am_t[i][3:0]},
				hw_t[j], 1, 1);
		end
		issue(ahs_pair_half_shift_left_sat, 0, 1, 32'h4000_0001, 0, 1);
		issue(ahs_accum_shift_imm, 1, 6'h3c, 0, 0, 0);
		issue(ahs_accum_shift_var, 2, 0, 32'h3c, 1, 0);
		// random mix, mostly back to back
		repeat (400) begin
			issue(ahs_op_t'(rnd[1:0]), rnd[3:2], rnd[9:4], lfsr(rnd),
				rnd[12:10] != 0, rnd[15:13] != 0);
			if (rnd[17:16] == 0) @(negedge ref_clk_i) op_valid_i = 0;
		end
		@(negedge ref_clk_i) op_valid_i = 0;
		repeat (3) @(negedge ref_clk_i);
		chk(q.size() == 0, "missing results");
		complete_run();
	end
endmodule
